/* ecp_cfg.svh */
// Purpose: constants of the cyclic process-data framer
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the register bus
`ifndef ECP_CFG_SVH
`define ECP_CFG_SVH

// timing
`define ECP_CLK_HZ        200000000
`define ECP_SPEED_PER_MS  5
`define ECP_STAMP_PER_MS  1000
`define ECP_TICK_CYCLES   (`ECP_CLK_HZ / 1000 * `ECP_SPEED_PER_MS)
`define ECP_TICKS_PER_SEC (`ECP_STAMP_PER_MS / `ECP_SPEED_PER_MS)
`define ECP_AVG_SAMPLES   200
`define ECP_RPM_FACTOR    60
`define ECP_POS_BITS      31
`define ECP_REV_BITS      12

// register map
`define ECP_ADR_W     8
`define ECP_REG_CTRL  8'h00
`define ECP_REG_STAT  8'h04
`define ECP_REG_PRST  8'h08
`define ECP_REG_ECODE 8'h0c
`define ECP_REG_SPEED 8'h10
`define ECP_REG_POS   8'h14

// control register fields
`define ECP_CTRL_ISO   0
`define ECP_CTRL_REQ   1
`define ECP_CTRL_TEL_L 2
`define ECP_CTRL_TEL_H 3
`define ECP_CTRL_RST   32'h0000_0000
`define ECP_ECODE_RST  16'h0001

// status register fields
`define ECP_ST_MCTL  0
`define ECP_ST_SYNC  1
`define ECP_ST_PARK  2
`define ECP_ST_ERR   3
`define ECP_ST_MFLT  4
`define ECP_ST_PRUN  5

// control and state word fields
`define ECP_SOL_H    15
`define ECP_SOL_L    12
`define ECP_C2_MCTL  10
`define ECP_S2_REQ   9
`define ECP_SC_ACK   15
`define ECP_SC_PARK  14
`define ECP_SC_ABS   13
`define ECP_SC_PRST  12
`define ECP_SC_PMOD  11
`define ECP_SS_ERR   15
`define ECP_SS_PARK  14
`define ECP_SS_ABS   13
`define ECP_SS_PRUN  12
`define ECP_SS_ACK   11
`define ECP_SOL_MAX  4'hf
`define ECP_SOL_MIN  4'h1

// telegram lengths in words
`define ECP_LEN_SHORT 4'h6
`define ECP_LEN_LONG  4'h8
`define ECP_LEN_VEND  4'h4
`define ECP_NWORDS    8

`endif

/* ecp_pkg.sv */
// Purpose: types of the cyclic process-data framer
// Assumes: nothing
// Notes:   constants live in ecp_cfg.svh
package ecp_pkg;
  typedef enum logic [1:0] {
    TELE_SHORT,
    TELE_LONG,
    TELE_VEND,
    TELE_SPARE
  } ecp_tele_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SEND
  } ecp_state_type;
endpackage

/* ecp_tick_if.sv */
// Purpose: carries the slow-rate enables between timebase and users
// Assumes: single clock domain
// Notes:   both signals are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface ecp_tick_if;
  logic tick_fast;
  logic tick_sec;
  modport src (output tick_fast, output tick_sec);
  modport dst (input tick_fast, input tick_sec);
endinterface
`default_nettype wire

/* ecp_timebase.sv */
// Purpose: sample-rate and one-second enables
// Assumes: clk_i at 200 MHz
// Notes:   tick_sec coincides with every Nth tick_fast
`timescale 1ns/1ps
`default_nettype none
`include "ecp_cfg.svh"
module ecp_timebase #(
  parameter int unsigned TICK_CYCLES   = `ECP_TICK_CYCLES,
  parameter int unsigned TICKS_PER_SEC = `ECP_TICKS_PER_SEC
)(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // enables
  ecp_tick_if.src  tb
);
  logic [31:0] cyc_cnt;
  logic [15:0] tick_cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cyc_cnt      <= '0;
      tb.tick_fast <= 1'b0;
    end else if (cyc_cnt == 32'(TICK_CYCLES - 1)) begin
      cyc_cnt      <= '0;
      tb.tick_fast <= 1'b1;
    end else begin
      cyc_cnt      <= cyc_cnt + 32'h1;
      tb.tick_fast <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt    <= '0;
      tb.tick_sec <= 1'b0;
    end else begin
      tb.tick_sec <= 1'b0;
      if (cyc_cnt == 32'(TICK_CYCLES - 1)) begin
        if (tick_cnt == 16'(TICKS_PER_SEC - 1)) begin
          tick_cnt    <= '0;
          tb.tick_sec <= 1'b1;
        end else begin
          tick_cnt <= tick_cnt + 16'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* ecp_speed.sv */
// Purpose: rpm from a moving window of position samples
// Assumes: one sample per tick_fast
// Notes:   reads zero until the window has filled once
`timescale 1ns/1ps
`default_nettype none
`include "ecp_cfg.svh"
module ecp_speed #(
  parameter int unsigned SAMPLES  = `ECP_AVG_SAMPLES,
  parameter int unsigned REV_BITS = `ECP_REV_BITS
)(
  // system
  input wire logic        clk_i,
  input wire logic        rst_i,
  // enables and sample
  ecp_tick_if.dst         tb,
  input wire logic [31:0] pos_i,
  // result
  output logic     [15:0] speed_o
);
  logic [31:0] ring [SAMPLES];
  logic [7:0]  idx;
  logic        full;
  logic signed [31:0] delta;
  logic signed [47:0] scaled;

  // window sum of per-sample deltas equals newest minus oldest
  assign delta  = $signed(pos_i - ring[idx]);
  assign scaled = (48'(delta) * 48'(`ECP_RPM_FACTOR)) >>> REV_BITS;

  always_ff @(posedge clk_i) begin
    if (tb.tick_fast) begin
      ring[idx] <= pos_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx  <= '0;
      full <= 1'b0;
    end else if (tb.tick_fast) begin
      if (idx == 8'(SAMPLES - 1)) begin
        idx  <= '0;
        full <= 1'b1;
      end else begin
        idx <= idx + 8'h1;
      end
    end
  end

  // refreshed once per sample period, saturated to 16 bits
  always_ff @(posedge clk_i) begin
    if (rst_i || !full) begin
      speed_o <= '0;
    end else if (tb.tick_fast) begin
      if (scaled > 48'sd32767) begin
        speed_o <= 16'h7fff;
      end else if (scaled < -48'sd32768) begin
        speed_o <= 16'h8000;
      end else begin
        speed_o <= scaled[15:0];
      end
    end
  end
endmodule
`default_nettype wire

/* ecp_framer.sv */
// Purpose: cyclic process-data framer of an absolute encoder slave
// Assumes: frame words come from fieldbus logic on clk_i
// Notes:   one response stream per accepted frame
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ecp_cfg.svh"
module ecp_framer #(
  parameter int unsigned TICK_CYCLES = `ECP_TICK_CYCLES,
  parameter int unsigned POS_BITS    = `ECP_POS_BITS,
  parameter int unsigned REV_BITS    = `ECP_REV_BITS
)(
  // system
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`ECP_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // sensor side
  input  wire logic [31:0]           raw_pos_i,
  input  wire logic                  enc_err_i,
  // cyclic frame from master
  input  wire logic                  frame_i,
  input  wire logic [15:0]           encoder_ctrl_word2_i,
  input  wire logic [15:0]           sensor_ctrl_word_i,
  output logic                       busy_o,
  // response word stream
  output logic                       tx_valid_o,
  input  wire logic                  tx_ready_i,
  output logic      [15:0]           tx_word_o,
  output logic                       tx_last_o
);
  ecp_tick_if tb ();

  ecp_pkg::ecp_state_type state;
  ecp_pkg::ecp_tele_type  tele;

  // registers
  logic [31:0] ctrl;
  logic [31:0] preset;
  logic [15:0] err_code;
  logic        mfault;
  logic        wb_hit;
  logic        wb_wr;
  logic [31:0] next_dat;

  // frame state
  logic [15:0] ctl2;
  logic [15:0] sctl;
  logic        prst_prev;
  logic        prst_run;
  logic        err_lat;
  logic        synced;
  logic [3:0]  msol;
  logic [3:0]  dsol;
  logic [3:0]  msol_exp;
  logic [31:0] offset;
  logic [31:0] pos_mask;
  logic [31:0] pos_out;
  logic [31:0] pos_left;
  logic [15:0] speed;
  logic [15:0] stamp;
  logic [15:0] esw2;
  logic [15:0] ssw;
  logic [31:0] right_fld;
  logic [31:0] left_fld;
  logic [31:0] speed32;
  logic [15:0] words [`ECP_NWORDS];
  logic [3:0]  len;
  logic [3:0]  widx;
  logic        iso;
  logic        park;

  ecp_timebase #(
    .TICK_CYCLES   (TICK_CYCLES),
    .TICKS_PER_SEC (`ECP_TICKS_PER_SEC)
  ) u_tb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb    (tb)
  );

  ecp_speed #(
    .SAMPLES  (`ECP_AVG_SAMPLES),
    .REV_BITS (REV_BITS)
  ) u_speed (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tb      (tb),
    .pos_i   (pos_out),
    .speed_o (speed)
  );

  assign iso  = ctrl[`ECP_CTRL_ISO];
  assign tele = ecp_pkg::ecp_tele_type'(ctrl[`ECP_CTRL_TEL_H:`ECP_CTRL_TEL_L]);
  assign park = sctl[`ECP_SC_PARK];

  // ---- register bus
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_hit && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  always_comb begin
    next_dat = '0;
    case (wb_adr_i)
      `ECP_REG_CTRL:  next_dat = ctrl;
      `ECP_REG_STAT: begin
        next_dat[`ECP_ST_MCTL] = ctl2[`ECP_C2_MCTL];
        next_dat[`ECP_ST_SYNC] = synced;
        next_dat[`ECP_ST_PARK] = park;
        next_dat[`ECP_ST_ERR]  = err_lat;
        next_dat[`ECP_ST_MFLT] = mfault;
        next_dat[`ECP_ST_PRUN] = prst_run;
      end
      `ECP_REG_PRST:  next_dat = preset;
      `ECP_REG_ECODE: next_dat = {16'h0000, err_code};
      `ECP_REG_SPEED: next_dat = {stamp, speed};
      `ECP_REG_POS:   next_dat = pos_out;
      default:        next_dat = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= next_dat;
    end
  end

  // byte-lane writes of the writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= `ECP_CTRL_RST;
      preset   <= '0;
      err_code <= `ECP_ECODE_RST;
    end else if (wb_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          case (wb_adr_i)
            `ECP_REG_CTRL: ctrl[b*8 +: 8]   <= wb_dat_i[b*8 +: 8];
            `ECP_REG_PRST: preset[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            `ECP_REG_ECODE: begin
              if (b < 2) begin
                err_code[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---- time stamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stamp <= '0;
    end else if (tb.tick_sec) begin
      stamp <= stamp + 16'h1;
    end
  end

  // ---- frame intake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl2 <= '0;
      sctl <= '0;
    end else if (frame_i && state == ecp_pkg::ST_IDLE) begin
      ctl2 <= encoder_ctrl_word2_i;
      sctl <= sensor_ctrl_word_i;
    end
  end

  // ---- sign of life
  assign msol     = encoder_ctrl_word2_i[`ECP_SOL_H:`ECP_SOL_L];
  assign msol_exp = (ctl2[`ECP_SOL_H:`ECP_SOL_L] == `ECP_SOL_MAX) ?
                    `ECP_SOL_MIN : ctl2[`ECP_SOL_H:`ECP_SOL_L] + 4'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i || !iso) begin
      synced <= 1'b0;
      dsol   <= `ECP_SOL_MIN;
    end else if (frame_i && state == ecp_pkg::ST_IDLE) begin
      if (!synced) begin
        synced <= (msol != 4'h0);
        dsol   <= `ECP_SOL_MIN;
      end else if (msol == 4'h0 || msol != msol_exp) begin
        synced <= 1'b0;
      end else begin
        dsol <= (dsol == `ECP_SOL_MAX) ? `ECP_SOL_MIN : dsol + 4'h1;
      end
    end
  end

  // sticky fault; a new fault wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mfault <= 1'b0;
    end else if (iso && synced && frame_i && state == ecp_pkg::ST_IDLE &&
                 (msol == 4'h0 || msol != msol_exp)) begin
      mfault <= 1'b1;
    end else if (wb_wr && wb_adr_i == `ECP_REG_STAT && wb_sel_i[0] &&
                 wb_dat_i[`ECP_ST_MFLT]) begin
      mfault <= 1'b0;
    end
  end

  // ---- encoder error latch, held until acknowledged
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_lat <= 1'b0;
    end else if (enc_err_i) begin
      err_lat <= 1'b1;
    end else if (state == ecp_pkg::ST_LOAD && sctl[`ECP_SC_ACK]) begin
      err_lat <= 1'b0;
    end
  end

  // ---- preset, taken on the frame that raises the activate bit
  assign pos_mask = (POS_BITS >= 32) ? 32'hffff_ffff :
                    32'((64'h1 << POS_BITS) - 64'h1);
  assign pos_out  = (raw_pos_i + offset) & pos_mask;
  assign pos_left = pos_out << (32 - POS_BITS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offset    <= '0;
      prst_prev <= 1'b0;
      prst_run  <= 1'b0;
    end else if (state == ecp_pkg::ST_LOAD) begin
      prst_prev <= sctl[`ECP_SC_PRST];
      if (sctl[`ECP_SC_PRST] && !prst_prev) begin
        prst_run <= 1'b1;
        if (sctl[`ECP_SC_PMOD]) begin
          offset <= offset + preset;
        end else begin
          offset <= preset - raw_pos_i;
        end
      end
    end else if (state == ecp_pkg::ST_SEND && tx_ready_i &&
                 widx == len - 4'h1 && !(prst_run && sctl[`ECP_SC_PRST] &&
                 !prst_prev)) begin
      prst_run <= 1'b0;
    end
  end

  // ---- state words, reserved bits stay zero
  always_comb begin
    esw2 = '0;
    if (iso && synced && !enc_err_i) begin
      esw2[`ECP_SOL_H:`ECP_SOL_L] = dsol;
    end
    esw2[`ECP_S2_REQ] = ctrl[`ECP_CTRL_REQ];
  end

  always_comb begin
    ssw = '0;
    ssw[`ECP_SS_ERR]  = err_lat;
    ssw[`ECP_SS_PARK] = park;
    ssw[`ECP_SS_ABS]  = sctl[`ECP_SC_ABS];
    // the response of the triggering frame already shows the preset running
    ssw[`ECP_SS_PRUN] = prst_run ||
                        (state == ecp_pkg::ST_LOAD && sctl[`ECP_SC_PRST] && !prst_prev);
    ssw[`ECP_SS_ACK]  = sctl[`ECP_SC_ACK] && err_lat;
  end

  always_comb begin
    if (park) begin
      right_fld = '0;
      left_fld  = '0;
    end else begin
      left_fld = pos_left;
      if (err_lat) begin
        right_fld = {16'h0000, err_code};
      end else if (sctl[`ECP_SC_ABS]) begin
        right_fld = pos_out;
      end else begin
        right_fld = '0;
      end
    end
  end

  assign speed32 = {{16{speed[15]}}, speed};

  // ---- response assembly and streaming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ecp_pkg::ST_IDLE;
      widx  <= '0;
      len   <= '0;
    end else begin
      case (state)
        ecp_pkg::ST_IDLE: begin
          widx <= '0;
          if (frame_i) begin
            state <= ecp_pkg::ST_LOAD;
          end
        end
        ecp_pkg::ST_LOAD: begin
          case (tele)
            ecp_pkg::TELE_SHORT: len <= `ECP_LEN_SHORT;
            ecp_pkg::TELE_LONG:  len <= `ECP_LEN_LONG;
            default:             len <= `ECP_LEN_VEND;
          endcase
          state <= ecp_pkg::ST_SEND;
        end
        ecp_pkg::ST_SEND: begin
          if (tx_ready_i) begin
            if (widx == len - 4'h1) begin
              state <= ecp_pkg::ST_IDLE;
            end
            widx <= widx + 4'h1;
          end
        end
        default: state <= ecp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `ECP_NWORDS; i++) begin
        words[i] <= '0;
      end
    end else if (state == ecp_pkg::ST_LOAD) begin
      if (tele == ecp_pkg::TELE_SHORT || tele == ecp_pkg::TELE_LONG) begin
        words[0] <= esw2;
        words[1] <= ssw;
        words[2] <= left_fld[31:16];
        words[3] <= left_fld[15:0];
        words[4] <= right_fld[31:16];
        words[5] <= right_fld[15:0];
        words[6] <= speed32[31:16];
        words[7] <= speed32[15:0];
      end else begin
        words[0] <= park ? 16'h0000 : pos_out[31:16];
        words[1] <= park ? 16'h0000 : pos_out[15:0];
        words[2] <= speed;
        words[3] <= stamp;
        words[4] <= '0;
        words[5] <= '0;
        words[6] <= '0;
        words[7] <= '0;
      end
    end
  end

  assign busy_o     = (state != ecp_pkg::ST_IDLE);
  assign tx_valid_o = (state == ecp_pkg::ST_SEND);
  assign tx_word_o  = words[widx[2:0]];
  assign tx_last_o  = tx_valid_o && (widx == len - 4'h1);
endmodule
`default_nettype wire

/* ecp_framer_asserts.sv */
// Purpose: port-level checks of the framer
// Assumes: bound to ecp_framer
// Notes:   telegram kind tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module ecp_framer_asserts (
  // system
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // frame side
  input wire logic        enc_err_i,
  input wire logic        frame_i,
  input wire logic        busy_o,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic [15:0] tx_word_o,
  input wire logic        tx_last_o
);
  logic [3:0] cnt;
  logic [3:0] ctl;
  logic [3:0] len;
  wire        take = tx_valid_o && tx_ready_i;
  wire        head = tx_valid_o && cnt == 4'h0 && !ctl[3];
  assign len = ctl[3] ? 4'h4 : (ctl[2] ? 4'h8 : 4'h6);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= 4'h0;
    end else if (wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
      ctl <= wb_dat_i[3:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
    end else if (take) begin
      cnt <= tx_last_o ? 4'h0 : cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_WB_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_TX_LAT: assert property (frame_i && !busy_o |=> busy_o && !tx_valid_o ##1 tx_valid_o)
    else $error("response start latency wrong");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_word_o))
    else $error("word changed while stalled");
  AST_TX_LEN: assert property (take |-> tx_last_o == (cnt + 4'h1 == len))
    else $error("telegram length wrong");
  AST_TX_DONE: assert property (take && tx_last_o |=> !busy_o && !tx_valid_o)
    else $error("busy after last word");
  AST_ESW2_RSV: assert property (head |-> (tx_word_o & 16'h0dff) == 16'h0000)
    else $error("reserved state bits set");
  AST_ESW2_REQ: assert property (head |-> tx_word_o[9] == ctl[1])
    else $error("control request bit wrong");
  AST_SOL_ERR: assert property (head && (enc_err_i || !ctl[0]) |-> tx_word_o[15:12] == 4'h0)
    else $error("sign of life not zero");
endmodule
bind ecp_framer ecp_framer_asserts u_ecp_framer_asserts (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .enc_err_i(enc_err_i),
  .frame_i(frame_i), .busy_o(busy_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .tx_word_o(tx_word_o), .tx_last_o(tx_last_o));
`default_nettype wire

/* ecp_master_model.sv */
// Purpose: fieldbus master sending frames and taking responses
// Assumes: called right after a rising edge
// Notes:   stall mode drops ready at random
`timescale 1ns/1ps
`default_nettype none
module ecp_master_model (
  // system
  input  wire logic        clk_i,
  // frame toward device
  output logic             frame_o,
  output logic      [15:0] ctrl2_o,
  output logic      [15:0] sens_o,
  input  wire logic        busy_i,
  // response stream
  input  wire logic        valid_i,
  input  wire logic        last_i,
  output logic             ready_o
);
  logic stall = 1'b0;
  initial begin
    frame_o = 1'b0;
    ctrl2_o = 16'h0000;
    sens_o = 16'h0000;
    ready_o = 1'b1;
  end
  always @(posedge clk_i) ready_o <= stall ? 1'($urandom) : 1'b1;
  task automatic send(input logic [15:0] c2, input logic [15:0] sc, input logic st);
    stall = st;
    while (busy_i) @(posedge clk_i);
    frame_o <= 1'b1;
    ctrl2_o <= c2;
    sens_o <= sc;
    @(posedge clk_i);
    frame_o <= 1'b0;
    ctrl2_o <= ~c2;
    sens_o <= ~sc;
    do begin
      @(posedge clk_i);
    end while (!(valid_i && ready_o && last_i));
    // one idle edge so the checker takes the last word first
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* ecp_framer_bench.sv */
// Purpose: self-checking bench of the framer
// Assumes: master model on the frame side
// Notes:   expected words and reads wait in queues
`timescale 1ns/1ps
`default_nettype none
module ecp_framer_bench;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, err = 1'b0, ramp = 1'b0;
  logic        ack, frm, busy, vld, rdy, lst;
  logic [7:0]  adr = 8'h00;
  logic [15:0] c2, sc, word;
  logic [31:0] wdat = 32'h0, rdat, e, p;
  logic [31:0] pos = 32'h4000_0000, want = 32'h4000_0000;
  logic [63:0] r;
  logic [31:0] wq[$];
  logic [63:0] rq[$];
  logic [3:0]  m;
  int          mismatches = 0, compares = 0;
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) pos <= ramp ? pos - 32'h1 : want;
  ecp_framer #(.TICK_CYCLES(20)) u_ecp_framer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .raw_pos_i(pos), .enc_err_i(err), .frame_i(frm),
    .encoder_ctrl_word2_i(c2), .sensor_ctrl_word_i(sc), .busy_o(busy), .tx_valid_o(vld),
    .tx_ready_i(rdy), .tx_word_o(word), .tx_last_o(lst));
  ecp_master_model u_ecp_master_model (.clk_i(clk_i), .frame_o(frm), .ctrl2_o(c2),
    .sens_o(sc), .busy_i(busy), .valid_i(vld), .last_i(lst), .ready_o(rdy));
  task automatic chk16(input logic [15:0] g, input logic [15:0] x, input logic [15:0] k);
    compares++;
    if ((g & k) !== (x & k)) begin
      mismatches++;
      $display("ERROR %0t word %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] x, input logic [31:0] k);
    compares++;
    if ((g & k) !== (x & k)) begin
      mismatches++;
      $display("ERROR %0t read %h exp %h", $time, g, x);
    end
  endtask
  always @(posedge clk_i) begin
    if (vld && rdy) begin
      e = wq.pop_front();
      chk16(word, e[15:0], e[31:16]);
      chk16({15'h0, lst}, {15'h0, wq.size() == 0}, 16'h0001);
    end
    if (ack && !we) begin
      r = rq.pop_front();
      chk32(rdat, r[31:0], r[63:32]);
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (!ack);
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] k);
    rq.push_back({k, v});
    wb(1'b0, a, 32'h0);
  endtask
  task automatic ew(input logic [15:0] v, input logic [15:0] k);
    wq.push_back({k, v});
  endtask
  task automatic ef(input logic [15:0] e2, em, ss, sm, input logic [31:0] l, rt,
                    input logic [15:0] pm);
    ew(e2, em);
    ew(ss, sm);
    ew(l[31:16], pm);
    ew(l[15:0], pm);
    ew(rt[31:16], pm);
    ew(rt[15:0], pm);
  endtask
  // reserved bits and stalls are random
  task automatic fr(input logic [15:0] a, input logic [15:0] b);
    u_ecp_master_model.send(a | (16'($urandom) & 16'h0bff), b | (16'($urandom) & 16'h07ff),
                            1'($urandom));
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(10353));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, 32'h0, 32'hffff_ffff);
    rd(8'h0c, 32'h1, 32'hffff_ffff);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    ramp <= 1'b1;
    repeat (5200) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h4);
    ef(16'h0, 16'hffff, 16'h0, 16'hffff, 32'h0, 32'h0, 16'h0);
    ew(16'hffff, 16'hffff);
    ew(16'h8000, 16'h8000);
    fr(16'h0, 16'h0);
    rd(8'h10, 32'h0001_8000, 32'hffff_8000);
    p = $urandom & 32'h3fff_ffff;
    ramp <= 1'b0;
    want <= p;
    wb(1'b1, 8'h00, 32'h2);
    ef(16'h0200, 16'hffff, 16'h0, 16'hffff, p << 1, 32'h0, 16'hffff);
    fr(16'h0, 16'h0);
    ef(16'h0200, 16'hffff, 16'h2000, 16'hffff, p << 1, p, 16'hffff);
    fr(16'h0, 16'h2000);
    wb(1'b1, 8'h00, 32'h8);
    ew(p[31:16], 16'hffff);
    ew(p[15:0], 16'hffff);
    ew(16'h0, 16'h0);
    ew(16'h0001, 16'hffff);
    fr(16'h0, 16'h0);
    wb(1'b1, 8'h00, 32'h1);
    for (int i = 0; i < 16; i++) begin
      m = 4'(i % 15 + 1);
      ef({m, 12'h0}, 16'hffff, (i == 4) ? 16'h4000 : 16'h0, 16'hffff,
         (i == 4) ? 32'h0 : p << 1, 32'h0, 16'hffff);
      fr({m, 12'h400}, (i == 4) ? 16'h4000 : 16'h0);
    end
    rd(8'h04, 32'h1, 32'h1);
    err <= 1'b1;
    ef(16'h0, 16'hf000, 16'h8000, 16'h8800, p << 1, 32'h1, 16'hffff);
    fr(16'h2400, 16'h0);
    err <= 1'b0;
    ef(16'h0, 16'h0, 16'h0, 16'h0, 32'h0, 32'h0, 16'h0);
    fr(16'h3400, 16'h8000);
    ef(16'h0, 16'h0, 16'h0, 16'h8000, p << 1, 32'h0, 16'hffff);
    fr(16'h4400, 16'h0);
    ef(16'h0, 16'hf000, 16'h0, 16'h0, 32'h0, 32'h0, 16'h0);
    fr(16'h0400, 16'h0);
    rd(8'h04, 32'h10, 32'h10);
    wb(1'b1, 8'h04, 32'h10);
    rd(8'h04, 32'h0, 32'h10);
    ef(16'h0, 16'h0, 16'h0, 16'h0, 32'h0, 32'h0, 16'h0);
    fr(16'h3400, 16'h0);
    ef(16'h0, 16'hf000, 16'h0, 16'h0, 32'h0, 32'h0, 16'h0);
    fr(16'h5400, 16'h0);
    rd(8'h04, 32'h10, 32'h10);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h08, 32'h1234);
    ef(16'h0, 16'hffff, 16'h2000, 16'hffff, p << 1, p, 16'hffff);
    fr(16'h0, 16'h2000);
    ef(16'h0, 16'hffff, 16'h1000, 16'hffff, 32'h0, 32'h0, 16'h0);
    fr(16'h0, 16'h1000);
    ef(16'h0, 16'hffff, 16'h2000, 16'hffff, 32'h2468, 32'h1234, 16'hffff);
    fr(16'h0, 16'h2000);
    wb(1'b1, 8'h08, 32'h10);
    ef(16'h0, 16'hffff, 16'h1000, 16'hffff, 32'h0, 32'h0, 16'h0);
    fr(16'h0, 16'h1800);
    ef(16'h0, 16'hffff, 16'h2000, 16'hffff, 32'h2488, 32'h1244, 16'hffff);
    fr(16'h0, 16'h2000);
    repeat (5) @(posedge clk_i);
    stop_test();
  end
endmodule
`default_nettype wire
